// *** hw/rtc_regs_pkg.sv ***
package rtc_regs_pkg;
    // Register indices; byte address on APB is index * 4
    localparam logic [5:0] IDX_CTRL_INT = 6'h01;
    localparam logic [5:0] IDX_INT_FLAG = 6'h02;
    localparam logic [5:0] IDX_AL_WDAY = 6'h14;
    localparam logic [5:0] IDX_AL_MON = 6'h15;
    localparam logic [5:0] IDX_AL_YEAR = 6'h16;
    localparam logic [5:0] IDX_CD_LO = 6'h18;
    localparam logic [5:0] IDX_CD_HI = 6'h19;
    localparam logic [5:0] IDX_TEMP = 6'h20;
    localparam logic [5:0] IDX_USER0 = 6'h28;
    localparam logic [5:0] IDX_USER1 = 6'h29;
    localparam logic [5:0] IDX_THERM_CTRL = 6'h30;
    localparam int ADDR_W = 8;

    localparam int ALARM_EN_BIT = 7;
    localparam int WDAY_W = 3;
    localparam int MON_W = 5;
    localparam int YEAR_W = 7;
    localparam int FLAG_ALARM_BIT = 0;
    localparam int FLAG_TEMP_BIT = 1;
    localparam int THERM_EN_BIT = 1;
    localparam int EVT_W = 2;

    // Stored bits; unused positions read as zero
    localparam logic [7:0] WDAY_MASK = 8'h87;
    localparam logic [7:0] MON_MASK = 8'h9f;
    localparam logic [7:0] YEAR_MASK = 8'hff;

    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic [7:0] RST_CD = 8'h00;
    localparam logic [7:0] RST_USER = 8'h00;
    localparam logic [7:0] RST_TEMP = 8'h3c;
    localparam logic RST_THERM_EN = 1'b1;
    localparam logic [EVT_W-1:0] RST_MASK = 2'h0;

    // Temperature code is degrees plus 60; 0 = -60, 60 = 0, 250 = +190
    localparam logic [7:0] TEMP_ZERO_CODE = 8'h3c;
    localparam logic [7:0] TEMP_MAX_CODE = 8'hfa;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_FETCH = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

    function automatic logic [7:0] temp_clamp(input logic [7:0] code);
        temp_clamp = (code > TEMP_MAX_CODE) ? TEMP_MAX_CODE : code;
    endfunction
endpackage

// *** hw/alarm_cmp_if.sv ***
`timescale 1ns/1ps
interface alarm_cmp_if;
    logic [7:0] alarm_weekday;
    logic [7:0] alarm_month;
    logic [7:0] alarm_year;
    logic [rtc_regs_pkg::WDAY_W-1:0] now_weekday;
    logic [rtc_regs_pkg::MON_W-1:0] now_month;
    logic [rtc_regs_pkg::YEAR_W-1:0] now_year;
    logic fields_match;
    logic any_enabled;

    modport regs (
        output alarm_weekday, alarm_month, alarm_year,
        output now_weekday, now_month, now_year,
        input fields_match, any_enabled
    );
    modport cmp (
        input alarm_weekday, alarm_month, alarm_year,
        input now_weekday, now_month, now_year,
        output fields_match, any_enabled
    );
endinterface

// *** hw/alarm_compare.sv ***
`timescale 1ns/1ps
module alarm_compare (
    input wire logic pclk,
    input wire logic presetn,
    alarm_cmp_if.cmp c
);
    import rtc_regs_pkg::*;

    logic weekday_alarm_enable;
    logic month_alarm_enable;
    logic year_alarm_enable;
    logic weekday_hit;
    logic month_hit;
    logic year_hit;

    always_comb begin
        weekday_alarm_enable = c.alarm_weekday[ALARM_EN_BIT];
        month_alarm_enable = c.alarm_month[ALARM_EN_BIT];
        year_alarm_enable = c.alarm_year[ALARM_EN_BIT];
        // Only the value bits take part; unused bits are don't-care
        weekday_hit = c.alarm_weekday[WDAY_W-1:0] == c.now_weekday;
        month_hit = c.alarm_month[MON_W-1:0] == c.now_month;
        year_hit = c.alarm_year[YEAR_W-1:0] == c.now_year;
        c.fields_match = (!weekday_alarm_enable || weekday_hit)
            && (!month_alarm_enable || month_hit)
            && (!year_alarm_enable || year_hit);
        c.any_enabled = weekday_alarm_enable || month_alarm_enable
            || year_alarm_enable;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_disabled_ignored;
        !c.any_enabled |-> c.fields_match;
    endproperty
    a_disabled_ignored: assert property (p_disabled_ignored)
        else $error("disabled alarm fields blocked the match");

    property p_wday_mismatch;
        (c.alarm_weekday[ALARM_EN_BIT]
            && c.alarm_weekday[WDAY_W-1:0] != c.now_weekday)
            |-> !c.fields_match;
    endproperty
    a_wday_mismatch: assert property (p_wday_mismatch)
        else $error("enabled weekday mismatch still matched");

    property p_month_mismatch;
        (c.alarm_month[ALARM_EN_BIT]
            && c.alarm_month[MON_W-1:0] != c.now_month) |-> !c.fields_match;
    endproperty
    a_month_mismatch: assert property (p_month_mismatch)
        else $error("enabled month mismatch still matched");
endmodule

// *** hw/rtc_alarm_timer_temp_regs.sv ***
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module rtc_alarm_timer_temp_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [rtc_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire logic [7:0] meas_temp,
    input wire logic [rtc_regs_pkg::WDAY_W-1:0] now_weekday,
    input wire logic [rtc_regs_pkg::MON_W-1:0] now_month,
    input wire logic [rtc_regs_pkg::YEAR_W-1:0] now_year,
    input wire logic other_alarm_match,
    input wire logic other_alarm_enabled,
    output logic [15:0] countdown_value,
    output logic irq
);
    import rtc_regs_pkg::*;

    bus_state_t state, next_state;
    logic [31:0] next_prdata;
    logic err, next_err;
    logic [7:0] alarm_weekday, next_alarm_weekday;
    logic [7:0] alarm_month, next_alarm_month;
    logic [7:0] alarm_year, next_alarm_year;
    logic [7:0] countdown_low_byte, next_countdown_low_byte;
    logic [7:0] countdown_high_byte, next_countdown_high_byte;
    logic [7:0] temperature_result, next_temperature_result;
    logic [7:0] temp_cache, next_temp_cache;
    logic [7:0] user_nv_byte0, next_user_nv_byte0;
    logic [7:0] user_nv_byte1, next_user_nv_byte1;
    logic therm_enable, next_therm_enable;
    logic [EVT_W-1:0] irq_mask, next_irq_mask;
    logic [EVT_W-1:0] irq_status, next_irq_status;
    logic match_q, next_match_q;

    logic [5:0] idx;
    logic mapped;
    logic [7:0] rd_byte;
    logic wr_done;
    logic rd_done;
    logic match_now;
    logic alarm_rise;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    alarm_cmp_if cmp_bus ();

    alarm_compare u_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .c(cmp_bus.cmp)
    );

    assign cmp_bus.alarm_weekday = alarm_weekday;
    assign cmp_bus.alarm_month = alarm_month;
    assign cmp_bus.alarm_year = alarm_year;
    assign cmp_bus.now_weekday = now_weekday;
    assign cmp_bus.now_month = now_month;
    assign cmp_bus.now_year = now_year;

    assign idx = paddr[ADDR_W-1:2];
    assign countdown_value = {countdown_high_byte, countdown_low_byte};
    assign pready = (state == BUS_DONE) && psel && penable;
    assign pslverr = pready && err;
    assign irq = |(irq_status & irq_mask);

    always_comb begin
        mapped = (paddr[1:0] == 2'b00);
        rd_byte = 8'h00;
        case (idx)
            IDX_CTRL_INT: rd_byte = {6'h00, irq_mask};
            IDX_INT_FLAG: rd_byte = {6'h00, irq_status};
            IDX_AL_WDAY: rd_byte = alarm_weekday;
            IDX_AL_MON: rd_byte = alarm_month;
            IDX_AL_YEAR: rd_byte = alarm_year;
            IDX_CD_LO: rd_byte = countdown_low_byte;
            IDX_CD_HI: rd_byte = countdown_high_byte;
            IDX_TEMP: rd_byte = temp_cache;
            IDX_USER0: rd_byte = user_nv_byte0;
            IDX_USER1: rd_byte = user_nv_byte1;
            IDX_THERM_CTRL: rd_byte = {6'h00, therm_enable, 1'b0};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        next_prdata = prdata;
        next_err = err;
        next_temp_cache = temp_cache;
        next_alarm_weekday = alarm_weekday;
        next_alarm_month = alarm_month;
        next_alarm_year = alarm_year;
        next_countdown_low_byte = countdown_low_byte;
        next_countdown_high_byte = countdown_high_byte;
        next_temperature_result = temperature_result;
        next_user_nv_byte0 = user_nv_byte0;
        next_user_nv_byte1 = user_nv_byte1;
        next_therm_enable = therm_enable;
        next_irq_mask = irq_mask;
        wr_done = pready && pwrite && !err;
        rd_done = pready && !pwrite && !err;

        case (state)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    // Snapshot so a measurement mid-access cannot tear
                    next_temp_cache = temperature_result;
                    next_state = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                next_prdata = (mapped && !pwrite) ? {24'h000000, rd_byte}
                    : 32'h00000000;
                next_err = !mapped;
                next_state = BUS_DONE;
            end
            BUS_DONE: begin
                if (pready) begin
                    next_state = BUS_IDLE;
                end
            end
            default: next_state = BUS_IDLE;
        endcase

        if (therm_enable && meas_valid) begin
            next_temperature_result = temp_clamp(meas_temp);
        end

        if (wr_done) begin
            case (idx)
                IDX_CTRL_INT: next_irq_mask = pwdata[EVT_W-1:0];
                IDX_AL_WDAY: next_alarm_weekday = pwdata[7:0] & WDAY_MASK;
                IDX_AL_MON: next_alarm_month = pwdata[7:0] & MON_MASK;
                IDX_AL_YEAR: next_alarm_year = pwdata[7:0] & YEAR_MASK;
                IDX_CD_LO: next_countdown_low_byte = pwdata[7:0];
                IDX_CD_HI: next_countdown_high_byte = pwdata[7:0];
                IDX_TEMP: begin
                    if (!therm_enable) begin
                        next_temperature_result = pwdata[7:0];
                    end
                end
                IDX_USER0: next_user_nv_byte0 = pwdata[7:0];
                IDX_USER1: next_user_nv_byte1 = pwdata[7:0];
                IDX_THERM_CTRL: next_therm_enable = pwdata[THERM_EN_BIT];
                default: next_irq_mask = irq_mask;
            endcase
        end

        // An alarm needs at least one enabled field anywhere
        match_now = cmp_bus.fields_match && other_alarm_match
            && (cmp_bus.any_enabled || other_alarm_enabled);
        next_match_q = match_now;
        alarm_rise = match_now && !match_q;
        evt_set = '0;
        evt_set[FLAG_ALARM_BIT] = alarm_rise && irq_mask[FLAG_ALARM_BIT];
        evt_set[FLAG_TEMP_BIT] = therm_enable && meas_valid;
        // Read clears every flag set at completion, even one set after the data was fetched; a new event wins the clear
        evt_clr = (rd_done && idx == IDX_INT_FLAG) ? irq_status : '0;
        next_irq_status = (irq_status & ~evt_clr) | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= BUS_IDLE;
            prdata <= 32'h00000000;
            err <= 1'b0;
            temp_cache <= RST_TEMP;
            alarm_weekday <= RST_ALARM;
            alarm_month <= RST_ALARM;
            alarm_year <= RST_ALARM;
            countdown_low_byte <= RST_CD;
            countdown_high_byte <= RST_CD;
            temperature_result <= RST_TEMP;
            user_nv_byte0 <= RST_USER;
            user_nv_byte1 <= RST_USER;
            therm_enable <= RST_THERM_EN;
            irq_mask <= RST_MASK;
            irq_status <= '0;
            match_q <= 1'b0;
        end else begin
            state <= next_state;
            prdata <= next_prdata;
            err <= next_err;
            temp_cache <= next_temp_cache;
            alarm_weekday <= next_alarm_weekday;
            alarm_month <= next_alarm_month;
            alarm_year <= next_alarm_year;
            countdown_low_byte <= next_countdown_low_byte;
            countdown_high_byte <= next_countdown_high_byte;
            temperature_result <= next_temperature_result;
            user_nv_byte0 <= next_user_nv_byte0;
            user_nv_byte1 <= next_user_nv_byte1;
            therm_enable <= next_therm_enable;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            match_q <= next_match_q;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_bus_latency;
        (state == BUS_IDLE && psel && !penable) ##1 (psel && penable)
            |-> !pready ##1 pready;
    endproperty
    a_bus_latency: assert property (p_bus_latency)
        else $error("APB answer not in second access cycle");

    property p_wday_store;
        (wr_done && idx == IDX_AL_WDAY)
            |=> alarm_weekday == ($past(pwdata[7:0]) & WDAY_MASK);
    endproperty
    a_wday_store: assert property (p_wday_store)
        else $error("weekday alarm write not stored");

    property p_month_store;
        (wr_done && idx == IDX_AL_MON)
            |=> alarm_month == ($past(pwdata[7:0]) & MON_MASK);
    endproperty
    a_month_store: assert property (p_month_store)
        else $error("month alarm write not stored");

    property p_year_store;
        (wr_done && idx == IDX_AL_YEAR) |=> alarm_year == $past(pwdata[7:0]);
    endproperty
    a_year_store: assert property (p_year_store)
        else $error("year alarm write not stored");

    property p_cd_high;
        (wr_done && idx == IDX_CD_HI)
            |=> countdown_value[15:8] == $past(pwdata[7:0])
            && countdown_value[7:0] == $past(countdown_value[7:0]);
    endproperty
    a_cd_high: assert property (p_cd_high)
        else $error("countdown high byte write wrong");

    property p_temp_clamp;
        (therm_enable && meas_valid && meas_temp > TEMP_MAX_CODE)
            |=> temperature_result == TEMP_MAX_CODE;
    endproperty
    a_temp_clamp: assert property (p_temp_clamp)
        else $error("temperature code above 250");

    property p_temp_frozen;
        (state != BUS_IDLE) |=> $stable(temp_cache);
    endproperty
    a_temp_frozen: assert property (p_temp_frozen)
        else $error("temperature copy changed during access");

    property p_temp_write_blocked;
        (wr_done && idx == IDX_TEMP && therm_enable && !meas_valid)
            |=> $stable(temperature_result);
    endproperty
    a_temp_write_blocked: assert property (p_temp_write_blocked)
        else $error("temperature written while thermometer on");

    property p_user_store;
        (wr_done && idx == IDX_USER1) |=> user_nv_byte1 == $past(pwdata[7:0]);
    endproperty
    a_user_store: assert property (p_user_store)
        else $error("user byte write not stored");

    property p_alarm_irq;
        (alarm_rise && irq_mask[FLAG_ALARM_BIT])
            |=> irq_status[FLAG_ALARM_BIT] && irq;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq)
        else $error("alarm match did not raise flag and irq");

    property p_alarm_read_zero;
        (pready && !pwrite && idx == IDX_AL_WDAY && !err)
            |-> prdata[6:3] == 4'h0;
    endproperty
    a_alarm_read_zero: assert property (p_alarm_read_zero)
        else $error("unused weekday alarm bits read non-zero");

    c_alarm_irq: cover property (alarm_rise && irq_mask[FLAG_ALARM_BIT]);
    c_temp_read: cover property (state != BUS_IDLE && idx == IDX_TEMP
        && meas_valid);
    c_bad_addr: cover property (pslverr);
    c_host_temp: cover property (wr_done && idx == IDX_TEMP && !therm_enable);
endmodule

// *** tb/apb_host.sv ***
`timescale 1ns/1ps
module apb_host (
    input wire logic pclk,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // Signals change only just after a rising edge and stay put until
    // pready is seen; no fixed latency is assumed
    task automatic xfer(input logic wr, input logic [7:0] addr,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look like the last value
        pwdata <= ~pwdata;
    endtask
endmodule

// *** tb/tb_rtc_alarm_timer_temp_regs.sv ***
`timescale 1ns/1ps
module tb_rtc_alarm_timer_temp_regs;
    import rtc_regs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] pwdata, prdata;
    logic meas_valid = 1'b0;
    logic [7:0] meas_temp = 8'h00;
    logic [WDAY_W-1:0] now_weekday = 3'd1;
    logic [MON_W-1:0] now_month = 5'h01;
    logic [YEAR_W-1:0] now_year = 7'h00;
    logic other_alarm_match = 1'b1;
    logic other_alarm_enabled = 1'b0;
    logic [15:0] countdown_value;
    int errors = 0;
    int checked = 0;

    always #20 pclk = ~pclk;

    rtc_alarm_timer_temp_regs dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_valid(meas_valid), .meas_temp(meas_temp),
        .now_weekday(now_weekday), .now_month(now_month),
        .now_year(now_year), .other_alarm_match(other_alarm_match),
        .other_alarm_enabled(other_alarm_enabled),
        .countdown_value(countdown_value), .irq(irq)
    );

    apb_host host_u (
        .pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    task automatic chk(input string n, input logic [31:0] x,
        input logic [31:0] g);
        checked++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b1, {i, 2'b00}, d, r, e);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] x,
        input string n);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b0, {i, 2'b00}, 8'h00, r, e);
        chk(n, {24'h00_0000, x}, r);
    endtask

    task automatic meas(input logic [7:0] v);
        @(posedge pclk);
        meas_valid <= 1'b1;
        meas_temp <= v;
        @(posedge pclk);
        meas_valid <= 1'b0;
        meas_temp <= ~v;
        @(posedge pclk);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset;
        logic [5:0] idx [8] = '{IDX_AL_WDAY, IDX_AL_MON, IDX_AL_YEAR,
            IDX_CD_LO, IDX_CD_HI, IDX_TEMP, IDX_USER0, IDX_USER1};
        for (int k = 0; k < 8; k++) begin
            rd(idx[k], (idx[k] == IDX_TEMP) ? RST_TEMP : 8'h00, "rst");
        end
        chk("irq_rst", 32'h0, {31'h0, irq});
        chk("cd_rst", 32'h0, {16'h0, countdown_value});
        $display("test reset done");
    endtask

    task automatic t_fields;
        wr(IDX_AL_WDAY, 8'hff);
        wr(IDX_AL_MON, 8'hff);
        wr(IDX_AL_YEAR, 8'hff);
        rd(IDX_AL_WDAY, WDAY_MASK, "wday");
        rd(IDX_AL_MON, MON_MASK, "mon");
        rd(IDX_AL_YEAR, 8'hff, "year");
        wr(IDX_AL_YEAR, 8'h79);
        rd(IDX_AL_YEAR, 8'h79, "year79");
        $display("test alarm fields done");
    endtask

    task automatic t_store;
        wr(IDX_CD_LO, 8'h34);
        wr(IDX_CD_HI, 8'h12);
        settle(1);
        chk("cd", 32'h1234, {16'h0, countdown_value});
        rd(IDX_CD_LO, 8'h34, "cd_lo");
        rd(IDX_CD_HI, 8'h12, "cd_hi");
        wr(IDX_USER0, 8'hff);
        wr(IDX_USER1, 8'h5a);
        rd(IDX_USER0, 8'hff, "user0");
        rd(IDX_USER1, 8'h5a, "user1");
        $display("test storage done");
    endtask

    task automatic t_temp;
        logic [31:0] r;
        logic e;
        wr(IDX_CTRL_INT, 8'h02);
        meas(8'hfa);
        rd(IDX_TEMP, 8'hfa, "temp_max");
        chk("irq_temp", 32'h1, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h02, "flag_temp");
        settle(0);
        chk("irq_clr", 32'h0, {31'h0, irq});
        meas(8'hff);
        rd(IDX_TEMP, TEMP_MAX_CODE, "temp_clamp");
        wr(IDX_TEMP, 8'h10);
        rd(IDX_TEMP, 8'hfa, "temp_ro");
        wr(IDX_THERM_CTRL, 8'h00);
        wr(IDX_TEMP, 8'h10);
        rd(IDX_TEMP, 8'h10, "temp_wr");
        meas(8'h20);
        rd(IDX_TEMP, 8'h10, "temp_off");
        wr(IDX_THERM_CTRL, 8'h02);
        wr(IDX_CTRL_INT, 8'h00);
        meas(8'h64);
        // Update lands in mid access; the read must show the old code
        fork
            host_u.xfer(1'b0, {IDX_TEMP, 2'b00}, 8'h00, r, e);
            begin
                @(posedge pclk);
                meas(8'h50);
            end
        join
        chk("temp_frozen", 32'h64, r);
        rd(IDX_TEMP, 8'h50, "temp_new");
        rd(IDX_INT_FLAG, 8'h02, "flag_masked");
        $display("test temperature done");
    endtask

    task automatic t_alarm;
        wr(IDX_AL_WDAY, 8'h83);
        wr(IDX_AL_MON, 8'h12);
        wr(IDX_AL_YEAR, 8'h45);
        wr(IDX_CTRL_INT, 8'h01);
        now_weekday <= 3'd3;
        settle(2);
        chk("irq_alarm", 32'h1, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h01, "flag_alarm");
        settle(0);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        now_weekday <= 3'd1;
        wr(IDX_AL_MON, 8'h92);
        now_weekday <= 3'd3;
        settle(3);
        chk("irq_block", 32'h0, {31'h0, irq});
        now_month <= 5'h12;
        settle(2);
        chk("irq_month", 32'h1, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h01, "flag_month");
        // The other alarm fields join the same AND
        other_alarm_match <= 1'b0;
        now_weekday <= 3'd1;
        settle(2);
        now_weekday <= 3'd3;
        settle(3);
        chk("irq_other", 32'h0, {31'h0, irq});
        other_alarm_match <= 1'b1;
        settle(2);
        chk("irq_other_ok", 32'h1, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h01, "flag_other");
        now_weekday <= 3'd1;
        wr(IDX_CTRL_INT, 8'h00);
        now_weekday <= 3'd3;
        settle(3);
        chk("irq_mask", 32'h0, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h00, "flag_mask");
        // All local fields off: only an enabled other field may fire
        wr(IDX_AL_WDAY, 8'h03);
        wr(IDX_AL_MON, 8'h12);
        wr(IDX_CTRL_INT, 8'h01);
        settle(3);
        chk("irq_none_on", 32'h0, {31'h0, irq});
        other_alarm_enabled <= 1'b1;
        settle(2);
        chk("irq_other_on", 32'h1, {31'h0, irq});
        rd(IDX_INT_FLAG, 8'h01, "flag_other_on");
        $display("test alarm done");
    endtask

    task automatic t_err;
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b0, 8'h51, 8'h00, r, e);
        chk("misalign_err", 32'h1, {31'h0, e});
        chk("misalign_data", 32'h0, r);
        host_u.xfer(1'b1, 8'hfc, 8'h77, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        rd(IDX_USER1, 8'h5a, "user_kept");
        $display("test errors done");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #800000;
        errors++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_store();
        t_temp();
        t_alarm();
        t_err();
        wrap_up();
    end
endmodule
